// ### atc_pkg.sv
package atc_pkg;
  // SPI op-codes
  localparam logic [7:0] OP_CTRL_WR = 8'h08;
  localparam logic [7:0] OP_CTRL_RD = 8'h84;
  localparam logic [7:0] OP_TX_GO = 8'h40;
  // Transmit control field positions
  localparam int BIT_DRIVER_FLOAT = 7;
  localparam int BIT_LABEL_REVERSE = 6;
  localparam int BIT_LAUNCH_MODE = 5;
  localparam int BIT_LOOPBACK = 4;
  localparam int BIT_PARITY_SENSE = 3;
  localparam int BIT_PARITY_INSERT = 2;
  localparam int BIT_RATE = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // SPI framing
  localparam logic [3:0] OPC_LAST = 4'h7;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam int LABEL_BITS = 8;
  localparam int PARITY_POS = 31;
  // Bit timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int HS_BIT_NS = 10000;
  localparam int HS_BIT_CYC = (HS_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LS_DIV = 8;
endpackage

// ### atc_sync.sv
`timescale 1ns/100ps
module atc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule

// ### atc_tx_ctrl.sv
`timescale 1ns/100ps
// How it works
// R01: Op-code 0x08 writes the transmit control byte and op-code 0x84 reads it back.
// R02: Bit 7 set releases the line driver outputs to high impedance; it resets to 0.
// R03: Bit 6 set reverses the order of the first eight bits of each transmitted word.
// R04: With bit 5 clear, queued words launch only after op-code 0x40 arrives.
// R05: With bit 5 set, a queued word launches as soon as one is available.
// R06: Bit 4 set routes the transmitter output into both receivers.
// R07: While bit 4 is set, data on both external receive channels is ignored.
// R08: While bit 4 is set, the external line driver is held at NULL.
// R09: With bit 2 clear, bit 32 goes out unchanged as data.
// R10: With bit 2 set, bit 32 is replaced by a computed parity bit.
// R11: Bit 3 picks odd parity when 0 and even parity when 1, only with insertion on.
// R12: Bit 0 clear selects the high rate, set selects the high rate divided by 8.
// R13: Bit 1 stores and reads back its value, and every bit clears on reset.
module atc_tx_ctrl
  import atc_pkg::*;
#(
  parameter int HS_CYC = HS_BIT_CYC,
  parameter int LS_FACTOR = LS_DIV
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // SPI pins
  input wire logic i_sck,
  input wire logic i_cs_b,
  input wire logic i_mosi,
  output logic o_miso,
  // Queued word from transmit FIFO
  input wire logic [31:0] i_tx_word,
  input wire logic i_tx_valid,
  output logic o_tx_launch,
  output logic [31:0] o_tx_word,
  output logic o_bit_tick,
  // Serializer line levels and driver pins
  input wire logic i_ser_hi,
  input wire logic i_ser_lo,
  output logic o_line_hi,
  output logic o_line_lo,
  output logic o_line_oe,
  // Receive channel pins and receiver inputs
  input wire logic [1:0] i_rx_hi,
  input wire logic [1:0] i_rx_lo,
  output logic [1:0] o_rcv_hi,
  output logic [1:0] o_rcv_lo
);
  localparam int LS_CYC = HS_CYC * LS_FACTOR;
  localparam int CW = $clog2(LS_CYC + 1);
  localparam logic [CW-1:0] HS_LAST = CW'(HS_CYC - 1);
  localparam logic [CW-1:0] LS_LAST = CW'(LS_CYC - 1);

  if (HS_CYC < 1 || LS_FACTOR < 1) begin : g_bad_timing
    $error("atc_tx_ctrl: bit timing must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [6:0] pins_s;
  logic sck_s;
  logic cs_sel_s;
  logic cs_b_s;
  logic mosi_s;
  logic [1:0] rx_hi_s;
  logic [1:0] rx_lo_s;

  atc_sync #(.WIDTH(7)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(i_rst_b),
    .i_async({i_sck, !i_cs_b, i_mosi, i_rx_hi, i_rx_lo}),
    .o_sync(pins_s)
  );
  // Select synchronised active high so reset reads as deselected
  assign {sck_s, cs_sel_s, mosi_s, rx_hi_s, rx_lo_s} = pins_s;
  assign cs_b_s = !cs_sel_s;

  ////////////////////////////////////////////////////////////////////////////
  // SPI slave, mode 0
  logic sck_d_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shin_ff;
  logic [7:0] op_ff;
  logic [7:0] shout_ff;
  logic miso_ff;
  logic [7:0] ctrl_ff;
  logic go_ff;
  logic frame_done_ff;

  wire sck_rise = !cs_b_s && sck_s && !sck_d_ff;
  wire sck_fall = !cs_b_s && !sck_s && sck_d_ff;
  wire [7:0] shin_nxt = {shin_ff[6:0], mosi_s};
  wire opc_done = sck_rise && (bit_cnt_ff == OPC_LAST);
  // Clocks past the sixteenth bit are ignored
  wire data_done = sck_rise && (bit_cnt_ff == DATA_LAST) && !frame_done_ff;
  wire wr_done = data_done && (op_ff == OP_CTRL_WR); // R01
  wire rd_start = opc_done && (shin_nxt == OP_CTRL_RD); // R01
  wire go_cmd = opc_done && (shin_nxt == OP_TX_GO); // R04

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sck_d_ff <= 1'b0;
      bit_cnt_ff <= '0;
      shin_ff <= '0;
      op_ff <= '0;
      frame_done_ff <= 1'b0;
    end else begin
      sck_d_ff <= sck_s;
      if (cs_b_s) begin
        bit_cnt_ff <= '0;
        op_ff <= '0;
        frame_done_ff <= 1'b0;
      end else if (sck_rise) begin
        shin_ff <= shin_nxt;
        if (data_done) begin
          frame_done_ff <= 1'b1;
        end
        if (bit_cnt_ff != DATA_LAST) begin
          bit_cnt_ff <= bit_cnt_ff + 4'h1;
        end
        if (opc_done) begin
          op_ff <= shin_nxt;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      shout_ff <= '0;
      miso_ff <= 1'b0;
    end else if (rd_start) begin
      shout_ff <= ctrl_ff; // R01
    end else if (sck_fall && op_ff == OP_CTRL_RD) begin
      miso_ff <= shout_ff[7];
      shout_ff <= {shout_ff[6:0], 1'b0};
    end
  end
  assign o_miso = miso_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit control register
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_ff <= CTRL_RESET; // R13
    end else if (wr_done) begin
      ctrl_ff <= shin_nxt; // R13
    end
  end

  wire driver_float = ctrl_ff[BIT_DRIVER_FLOAT];
  wire tx_label_reverse = ctrl_ff[BIT_LABEL_REVERSE];
  wire tx_launch_mode = ctrl_ff[BIT_LAUNCH_MODE];
  wire loopback_check = ctrl_ff[BIT_LOOPBACK];
  wire parity_sense = ctrl_ff[BIT_PARITY_SENSE];
  wire tx_parity_insert = ctrl_ff[BIT_PARITY_INSERT];
  wire low_rate = ctrl_ff[BIT_RATE];

  ////////////////////////////////////////////////////////////////////////////
  // Launch control and word formatting
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      go_ff <= 1'b0;
    end else if (go_cmd) begin
      go_ff <= 1'b1; // R04
    end else if (!i_tx_valid) begin
      go_ff <= 1'b0;
    end
  end
  assign o_tx_launch = i_tx_valid && (tx_launch_mode || go_ff); // R04 R05

  logic [LABEL_BITS-1:0] label_rev;
  always_comb begin
    for (int i = 0; i < LABEL_BITS; i++) begin
      label_rev[i] = i_tx_word[LABEL_BITS-1-i];
    end
  end
  wire [LABEL_BITS-1:0] label_out = tx_label_reverse ? label_rev : i_tx_word[LABEL_BITS-1:0]; // R03
  wire par_bit = parity_sense ? ^i_tx_word[PARITY_POS-1:0] : ~^i_tx_word[PARITY_POS-1:0]; // R11
  wire top_bit = tx_parity_insert ? par_bit : i_tx_word[PARITY_POS]; // R09 R10

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_tx_word <= '0;
    end else if (o_tx_launch) begin
      o_tx_word <= {top_bit, i_tx_word[PARITY_POS-1:LABEL_BITS], label_out};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit rate
  logic [CW-1:0] tick_cnt_ff;
  wire [CW-1:0] tick_last = low_rate ? LS_LAST : HS_LAST; // R12
  wire tick_wrap = (tick_cnt_ff >= tick_last);
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      tick_cnt_ff <= '0;
    end else if (tick_wrap) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + CW'(1);
    end
  end
  assign o_bit_tick = tick_wrap;

  ////////////////////////////////////////////////////////////////////////////
  // Line driver and loopback
  assign o_line_hi = i_ser_hi && !loopback_check; // R08
  assign o_line_lo = i_ser_lo && !loopback_check; // R08
  assign o_line_oe = !driver_float; // R02
  assign o_rcv_hi = loopback_check ? {2{i_ser_hi}} : rx_hi_s; // R06 R07
  assign o_rcv_lo = loopback_check ? {2{i_ser_lo}} : rx_lo_s; // R06 R07

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_write_frame;
    wr_done ##1 1'b1;
  endsequence

  a_reset_clear: assert property (@(posedge i_clk) !i_rst_b |=> ctrl_ff == CTRL_RESET) // R13
    else $error("control byte not cleared by reset");
  a_write_op: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    s_write_frame |-> ctrl_ff == $past(shin_nxt)) // R01
    else $error("write op-code did not load the control byte");
  a_hold_value: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    !wr_done |=> $stable(ctrl_ff)) // R13
    else $error("control byte changed without a write");
  a_read_load: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    rd_start |=> shout_ff == $past(ctrl_ff)) // R01
    else $error("read op-code did not capture the control byte");
  a_driver_float: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    wr_done && shin_nxt[BIT_DRIVER_FLOAT] |=> !o_line_oe) // R02
    else $error("driver not floated");
  a_label_rev: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_tx_launch && tx_label_reverse |=> o_tx_word[0] == $past(i_tx_word[7])) // R03
    else $error("label order not reversed");
  a_launch_cmd: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_tx_launch && !tx_launch_mode |-> go_ff) // R04
    else $error("launch without transmit enable");
  a_go_launch: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    go_cmd && i_tx_valid ##1 i_tx_valid |-> o_tx_launch) // R04
    else $error("transmit enable did not launch");
  a_launch_auto: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    tx_launch_mode && i_tx_valid |-> o_tx_launch) // R05
    else $error("automatic launch missing");
  a_loop_route: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    loopback_check |-> o_rcv_hi == {2{i_ser_hi}} && o_rcv_lo == {2{i_ser_lo}}) // R06 R07
    else $error("loopback not routed to receivers");
  a_null_hold: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    loopback_check |-> !o_line_hi && !o_line_lo) // R08
    else $error("line driver not held at NULL in loopback");
  a_parity_off: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_tx_launch && !tx_parity_insert |=> o_tx_word[31] == $past(i_tx_word[31])) // R09
    else $error("bit 32 altered without parity insertion");
  a_parity_on: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_tx_launch && tx_parity_insert |=> (^o_tx_word) == !$past(parity_sense)) // R10 R11
    else $error("inserted parity has wrong sense");
  a_rate_period: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    o_bit_tick ##1 $stable(ctrl_ff) |-> tick_cnt_ff == '0) // R12
    else $error("bit counter did not restart");
  a_rate_limit: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $stable(low_rate) && !low_rate |-> tick_cnt_ff <= HS_LAST) // R12
    else $error("high rate period exceeded");
endmodule

// ### atc_spi_host.sv
`timescale 1ns/100ps
module atc_spi_host (
  // Clock
  input wire logic i_clk,
  // SPI pins
  output logic o_sck,
  output logic o_cs_b,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sck = 1'b0;
    o_cs_b = 1'b1;
    o_mosi = 1'b0;
  end
  // Mode 0 frame, MSB first, read bits taken from the second byte
  task automatic frame(input logic [7:0] op, input logic [7:0] data, input int nbits,
                       output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, data};
    rd = 8'h00;
    @(negedge i_clk);
    o_cs_b = 1'b0;
    repeat (4) @(negedge i_clk);
    for (int i = 0; i < nbits; i++) begin
      o_mosi = sh[15 - i];
      repeat (6) @(negedge i_clk);
      if (i >= 8) rd = {rd[6:0], i_miso};
      o_sck = 1'b1;
      repeat (6) @(negedge i_clk);
      o_sck = 1'b0;
    end
    repeat (6) @(negedge i_clk);
    o_cs_b = 1'b1;
    // Released data line does not keep its last level
    o_mosi = ~o_mosi;
    repeat (6) @(negedge i_clk);
  endtask
endmodule

// ### test_arinc_tx_control_register.sv
`timescale 1ns/100ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module test_arinc_tx_control_register
  import atc_pkg::*;
;
  localparam int HS = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic sck;
  logic cs_b;
  logic mosi;
  logic miso;
  logic [31:0] tx_word = 32'h00000000;
  logic tx_valid = 1'b0;
  logic launch;
  logic [31:0] txw;
  logic tick;
  logic ser_hi = 1'b0;
  logic ser_lo = 1'b0;
  logic line_hi;
  logic line_lo;
  logic line_oe;
  logic [1:0] rx_hi = 2'h0;
  logic [1:0] rx_lo = 2'h0;
  logic [1:0] rcv_hi;
  logic [1:0] rcv_lo;
  logic [7:0] ctrl;
  logic [7:0] rd;
  logic [31:0] seed;
  int err_count = 0;
  int tests_run = 0;
  int n;

  always #25 clk = ~clk;

  atc_spi_host host (.i_clk(clk), .o_sck(sck), .o_cs_b(cs_b), .o_mosi(mosi), .i_miso(miso));

  atc_tx_ctrl #(.HS_CYC(HS), .LS_FACTOR(LS_DIV)) dut (
    .i_clk(clk), .i_rst_b(rst_b), .i_sck(sck), .i_cs_b(cs_b), .i_mosi(mosi), .o_miso(miso),
    .i_tx_word(tx_word), .i_tx_valid(tx_valid), .o_tx_launch(launch), .o_tx_word(txw),
    .o_bit_tick(tick), .i_ser_hi(ser_hi), .i_ser_lo(ser_lo), .o_line_hi(line_hi),
    .o_line_lo(line_lo), .o_line_oe(line_oe), .i_rx_hi(rx_hi), .i_rx_lo(rx_lo),
    .o_rcv_hi(rcv_hi), .o_rcv_lo(rcv_lo));

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // Expected transmitted word
  function automatic logic [31:0] fmt(input logic [31:0] x, input logic [7:0] c);
    logic [31:0] y;
    y = x;
    if (c[6]) for (int i = 0; i < 8; i++) y[i] = x[7 - i];
    if (c[2]) y[31] = ^x[30:0] ^ ~c[3];
    return y;
  endfunction

  // Cycles between two bit ticks
  task automatic tick_gap(output int g);
    g = 0;
    while (tick !== 1'b1 && g < 400) begin
      @(negedge clk);
      g++;
    end
    g = 0;
    do begin
      @(negedge clk);
      g++;
    end while (tick !== 1'b1 && g < 400);
  endtask

  task automatic print_verdict();
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'h0001869E;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    host.frame(OP_CTRL_RD, 8'h00, 16, rd);
    `CHK("ctrl_reset", CTRL_RESET, rd)
    for (int k = 0; k < 16; k++) begin
      seed = lfsr(seed);
      // Parity bits walk all four settings
      ctrl = {seed[7:4], k[1:0], seed[1:0]};
      host.frame(OP_CTRL_WR, ctrl, 16, rd);
      host.frame(8'h10, ~ctrl, 16, rd);
      // Frame cut short by chip select must not write
      host.frame(OP_CTRL_WR, ~ctrl, 12, rd);
      host.frame(OP_CTRL_RD, 8'h00, 16, rd);
      `CHK("ctrl_read", ctrl, rd)
      {ser_hi, ser_lo, rx_hi, rx_lo} = seed[13:8];
      repeat (4) @(negedge clk);
      `CHK("line_oe", ~ctrl[7], line_oe)
      `CHK("line", ctrl[4] ? 2'b00 : {ser_hi, ser_lo}, {line_hi, line_lo})
      `CHK("rcv_hi", ctrl[4] ? {2{ser_hi}} : rx_hi, rcv_hi)
      `CHK("rcv_lo", ctrl[4] ? {2{ser_lo}} : rx_lo, rcv_lo)
      seed = lfsr(seed);
      tx_word = seed;
      tx_valid = 1'b1;
      #1;
      `CHK("launch_now", ctrl[5], launch)
      if (!ctrl[5]) host.frame(OP_TX_GO, 8'h00, 8, rd);
      #1;
      `CHK("launch_go", 1'b1, launch)
      @(negedge clk);
      `CHK("tx_word", fmt(tx_word, ctrl), txw)
      tx_valid = 1'b0;
      tick_gap(n);
      `CHK("tick_gap", ctrl[0] ? HS * LS_DIV : HS, n)
    end
    // Mid-run reset clears every bit
    host.frame(OP_CTRL_WR, 8'hFF, 16, rd);
    `CHK("line_oe_set", 1'b0, line_oe)
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    `CHK("line_oe_rst", 1'b1, line_oe)
    host.frame(OP_CTRL_RD, 8'h00, 16, rd);
    `CHK("ctrl_rst", CTRL_RESET, rd)
    tick_gap(n);
    `CHK("tick_gap_rst", HS, n)
    print_verdict();
  end

  initial begin
    #2000000;
    err_count++;
    print_verdict();
  end
endmodule
